/* File: rtl/dpram_port.sv */
// Operation
// [R1] address, data and controls are captured on the rising clock edge only
// [R2] array write uses an internally timed pulse, not the clock edge itself
// [R3] active-low output enable gates the data outputs combinationally
// [R4] advance enable low without load increments the burst address; high stalls it
// [R5] load strobe low selects external address, high selects counter
// [R6] load strobe held low loads a fresh address every edge
// [R7] load and advance both high keep address and read data constant
// [R8] counter clear has no idle cycle; same-cycle access goes to address zero
// [R9] data pin drive state follows the controls sampled the cycle before
// [R10] one deselected sample puts the port into standby
// [R11] pipelined mode needs two selected samples before outputs re-enable
// [R12] controller rewrites the location after an idle cycle in read-write-read
// [R13] controller drives chip selects so one bank answers per upper address
// [R14] after deselect outputs go high impedance following the next edge
// [R15] output mode select is static: high pipelined, low flow-through
// [R16] port is selected only with low select low and high select high
// [R17] counter clear sets address zero and wins over advance
module dpram_port
    import dpram_port_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    input  wire port_ctrl_s        i_ctrl,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_data,
    input  wire logic              i_output_enable_n,
    input  wire logic              i_output_mode_select,
    output logic      [DATA_W-1:0] o_data,
    output logic                   o_data_oe,
    output logic                   o_standby
);
    logic [DATA_W-1:0] mem_q [DEPTH];
    port_ctrl_s        ctrl_q;
    logic [ADDR_W-1:0] ext_addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [ADDR_W-1:0] counter_q;
    logic [ADDR_W-1:0] int_addr;
    logic              sel;
    logic              wr_pulse;
    logic [DATA_W-1:0] flow_q;
    logic [DATA_W-1:0] pipe_q;
    logic              flow_drive_q;
    logic              pipe_drive_q;
    logic [1:0]        sel_run_q;
    logic              standby_q;
    logic [DATA_W-1:0] data_mux;
    logic              drive_mux;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            ctrl_q     <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
            ext_addr_q <= ZERO_LOCATION;
            wdata_q    <= '0;
        end
        else
        begin
            ctrl_q     <= i_ctrl; // [R1]
            ext_addr_q <= i_addr; // [R1]
            wdata_q    <= i_data; // [R1]
        end
    end

    assign sel = !ctrl_q.select_low_active && ctrl_q.select_high_active; // [R16]

    // clear forces zero into the access of the same cycle
    always_comb
    begin
        if (!ctrl_q.counter_clear_n)
            int_addr = ZERO_LOCATION; // [R8]
        else if (!ctrl_q.address_load_strobe_n)
            int_addr = ext_addr_q; // [R5] [R6]
        else
            int_addr = counter_q; // [R5]
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            counter_q <= ZERO_LOCATION;
        else if (!i_ctrl.counter_clear_n)
            counter_q <= ZERO_LOCATION; // [R17]
        else if (!i_ctrl.address_load_strobe_n)
            counter_q <= i_addr; // [R6]
        else if (!i_ctrl.counter_advance_enable_n)
            counter_q <= int_addr + ADDR_STEP; // [R4]
        else
            counter_q <= int_addr; // [R7]
    end

    write_pulse_gen u_wpulse (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_start   (sel && !ctrl_q.read_write),
        .o_pulse   (wr_pulse)
    );

    // data and address are held by the pulse generator timing, one write per access
    logic [ADDR_W-1:0] waddr_q;
    logic [DATA_W-1:0] wbuf_q;
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            waddr_q <= ZERO_LOCATION;
            wbuf_q  <= '0;
        end
        else if (sel && !ctrl_q.read_write)
        begin
            waddr_q <= int_addr;
            wbuf_q  <= wdata_q;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (wr_pulse)
            mem_q[waddr_q] <= wbuf_q; // [R2]
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            sel_run_q <= SEL_RUN_ZERO;
        else if (!sel)
            sel_run_q <= SEL_RUN_ZERO; // [R11]
        else if (sel_run_q != SEL_RUN_NEEDED)
            sel_run_q <= sel_run_q + SEL_RUN_ONE; // [R11]
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            standby_q <= 1'b1;
        else
            standby_q <= !sel; // [R10]
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            flow_q       <= '0;
            flow_drive_q <= 1'b0;
            pipe_q       <= '0;
            pipe_drive_q <= 1'b0;
        end
        else
        begin
            if (sel && ctrl_q.read_write)
                flow_q <= mem_q[int_addr];
            flow_drive_q <= sel && ctrl_q.read_write; // [R9] [R14]
            pipe_q       <= flow_q;
            pipe_drive_q <= flow_drive_q && sel && (sel_run_q != SEL_RUN_ZERO); // [R11] [R14]
        end
    end

    assign data_mux  = i_output_mode_select ? pipe_q : flow_q; // [R15]
    assign drive_mux = i_output_mode_select ? pipe_drive_q : flow_drive_q;

    // output enable is asynchronous by design, so these two bypass a flop
    assign o_data    = data_mux;
    assign o_data_oe = drive_mux && !i_output_enable_n; // [R3]
    assign o_standby = standby_q;

    property p_standby_follows;
        @(posedge i_clk_sys) disable iff (i_rst)
        !sel |=> o_standby;
    endproperty
    a_standby_follows: assert property (p_standby_follows) // [R10]
        else $error("standby missing after deselect");

    property p_clear_zero;
        @(posedge i_clk_sys) disable iff (i_rst)
        !i_ctrl.counter_clear_n |=> counter_q == ZERO_LOCATION;
    endproperty
    a_clear_zero: assert property (p_clear_zero) // [R17]
        else $error("counter clear failed");

    property p_hold_addr;
        @(posedge i_clk_sys) disable iff (i_rst)
        i_ctrl.address_load_strobe_n && i_ctrl.counter_advance_enable_n
        && i_ctrl.counter_clear_n |=> counter_q == $past(int_addr);
    endproperty
    a_hold_addr: assert property (p_hold_addr) // [R7]
        else $error("address not held");

    property p_advance;
        @(posedge i_clk_sys) disable iff (i_rst)
        i_ctrl.address_load_strobe_n && !i_ctrl.counter_advance_enable_n
        && i_ctrl.counter_clear_n |=> counter_q == $past(int_addr) + ADDR_STEP;
    endproperty
    a_advance: assert property (p_advance) // [R4]
        else $error("counter did not advance");

    property p_oe_async;
        @(posedge i_clk_sys) disable iff (i_rst)
        i_output_enable_n |-> !o_data_oe;
    endproperty
    a_oe_async: assert property (p_oe_async) // [R3]
        else $error("driving with output enable high");

    property p_hiz_deselect;
        @(posedge i_clk_sys) disable iff (i_rst)
        !sel && !i_output_mode_select |=> !o_data_oe;
    endproperty
    a_hiz_deselect: assert property (p_hiz_deselect) // [R14]
        else $error("outputs active after deselect");

    property p_pipe_reenable;
        @(posedge i_clk_sys) disable iff (i_rst)
        i_output_mode_select && !sel ##1 sel |=> !o_data_oe;
    endproperty
    a_pipe_reenable: assert property (p_pipe_reenable) // [R11]
        else $error("pipelined outputs re-enabled too early");

    // every write access gets exactly one pulse cycle, back-to-back ones too
    property p_write_once;
        @(posedge i_clk_sys) disable iff (i_rst)
        wr_pulse == $past(sel && !ctrl_q.read_write);
    endproperty
    a_write_once: assert property (p_write_once) // [R2]
        else $error("write pulse does not match write access");
endmodule

/* File: include/dpram_port_pkg.sv */
package dpram_port_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int DEPTH  = 65536;
    localparam logic [ADDR_W-1:0] ZERO_LOCATION = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_STEP     = 16'h0001;
    localparam logic [1:0] SEL_RUN_NEEDED = 2'h2;
    localparam logic [1:0] SEL_RUN_ONE    = 2'h1;
    localparam logic [1:0] SEL_RUN_ZERO   = 2'h0;

    typedef struct packed {
        logic              select_low_active;
        logic              select_high_active;
        logic              read_write;
        logic              address_load_strobe_n;
        logic              counter_advance_enable_n;
        logic              counter_clear_n;
    } port_ctrl_s;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_WRITE = 2'h1,
        ST_DONE  = 2'h3
    } write_pulse_e;
endpackage

/* File: rtl/write_pulse_gen.sv */
module write_pulse_gen
    import dpram_port_pkg::*;
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_start,
    output logic      o_pulse
);
    write_pulse_e state_q;

    // one pulse cycle per write access; back-to-back writes keep it high so none is lost
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            state_q <= ST_IDLE;
        else
            case (state_q)
                ST_IDLE:  state_q <= i_start ? ST_WRITE : ST_IDLE;
                ST_WRITE: state_q <= i_start ? ST_WRITE : ST_DONE;
                ST_DONE:  state_q <= i_start ? ST_WRITE : ST_IDLE;
                default:  state_q <= ST_IDLE;
            endcase
    end

    assign o_pulse = (state_q == ST_WRITE);
endmodule

/* File: tb/bus_ctrl_model.sv */
module bus_ctrl_model
    import dpram_port_pkg::*;
(
    input  wire logic              i_clk_sys,
    output port_ctrl_s             o_ctrl,
    output logic      [ADDR_W-1:0] o_addr,
    output logic      [DATA_W-1:0] o_data,
    output logic                   o_output_enable_n,
    output logic                   o_output_mode_select
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        o_ctrl               = 6'h2F;
        o_addr               = 16'h0000;
        o_data               = 8'h00;
        o_output_enable_n    = 1'h0;
        o_output_mode_select = 1'h0;
    end

    // both selects always move together, one bank only
    // idle lines flip so a stale value never looks valid
    task automatic cyc(input logic s, input logic [3:0] op,
                       input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        #1;
        o_ctrl = {~s, s, op};
        o_addr = s ? a : ~o_addr;
        o_data = (s && !op[3]) ? d : ~o_data;
        @(posedge i_clk_sys);
    endtask
endmodule

/* File: tb/tb_top.sv */
module tb_top
    import dpram_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk_sys = 1'h0;
    logic              rst     = 1'h1;
    port_ctrl_s        ctrl;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              oe_n;
    logic              mode;
    logic              data_oe;
    logic              standby;
    int                num_errors = 0;
    int                checked    = 0;

    always #20 clk_sys = ~clk_sys;

    bus_ctrl_model m (.i_clk_sys(clk_sys), .o_ctrl(ctrl), .o_addr(addr), .o_data(wdata),
                      .o_output_enable_n(oe_n), .o_output_mode_select(mode));

    dpram_port dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_ctrl(ctrl), .i_addr(addr),
                    .i_data(wdata), .i_output_enable_n(oe_n), .i_output_mode_select(mode),
                    .o_data(rdata), .o_data_oe(data_oe), .o_standby(standby));

    task automatic close_out;
        if (num_errors == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic reset_run;
        rst = 1'h1;
        repeat (10) @(posedge clk_sys);
        #1 chk("standby", 8'h01, {7'h00, standby});
        chk("data_oe", 8'h00, {7'h00, data_oe});
        rst = 1'h0;
    endtask

    // op is {load_n, advance_n, clear_n}; then the address is held
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [2:0] op, input int lat,
                      input logic [DATA_W-1:0] e);
        m.cyc(1'h1, {1'h1, op}, a, 8'h00);
        repeat (lat) m.cyc(1'h1, 4'hF, a, 8'h00);
        #1 chk("rdata", e, rdata);
        chk("data_oe", 8'h01, {7'h00, data_oe});
        repeat (2) m.cyc(1'h1, 4'hF, a, 8'h00);
        #1 chk("held rdata", e, rdata);
    endtask

    initial
    begin
        reset_run();
        m.cyc(1'h1, 4'h3, 16'h1230, 8'hA0);
        m.cyc(1'h1, 4'h5, 16'h0000, 8'hA1);
        m.cyc(1'h1, 4'h5, 16'h0000, 8'hA2);
        m.cyc(1'h1, 4'h6, 16'h0000, 8'h5A);
        m.cyc(1'h0, 4'h3, 16'h1230, 8'hEE);
        repeat (3) m.cyc(1'h0, 4'hF, 16'h0000, 8'h00);
        #1 chk("standby", 8'h01, {7'h00, standby});
        chk("data_oe", 8'h00, {7'h00, data_oe});
        rd(16'h1232, 3'h3, 2, 8'hA2);
        rd(16'h1230, 3'h3, 2, 8'hA0);
        rd(16'hFFFF, 3'h5, 2, 8'hA1);
        rd(16'hFFFF, 3'h4, 2, 8'h5A);
        // write, idle, then rewrite before the next read
        m.cyc(1'h1, 4'h3, 16'h1240, 8'hC3);
        m.cyc(1'h0, 4'hF, 16'h0000, 8'h00);
        m.cyc(1'h1, 4'h3, 16'h1240, 8'hC3);
        rd(16'h1240, 3'h3, 2, 8'hC3);
        m.o_output_enable_n = 1'h1;
        #1 chk("data_oe", 8'h00, {7'h00, data_oe});
        // keep the enable high across an edge so the sampled check sees it
        m.cyc(1'h1, 4'hF, 16'h0000, 8'h00);
        #1 chk("data_oe", 8'h00, {7'h00, data_oe});
        m.o_output_enable_n = 1'h0;
        #1 chk("data_oe", 8'h01, {7'h00, data_oe});
        m.cyc(1'h0, 4'hF, 16'h0000, 8'h00);
        m.cyc(1'h0, 4'hF, 16'h0000, 8'h00);
        #1 chk("data_oe", 8'h00, {7'h00, data_oe});
        m.o_output_mode_select = 1'h1;
        reset_run();
        rd(16'h1231, 3'h3, 3, 8'hA1);
        // a single selected read between deselects must not reach the pins
        m.cyc(1'h0, 4'hF, 16'h0000, 8'h00);
        m.cyc(1'h1, 4'hB, 16'h1231, 8'h00);
        repeat (2) m.cyc(1'h0, 4'hF, 16'h0000, 8'h00);
        #1 chk("data_oe", 8'h00, {7'h00, data_oe});
        close_out();
    end
endmodule
